// >>> common/pmt_pkg.sv
// Constants and types for the program memory and table read block.
package pmt_pkg;
  localparam int          PM_AW          = 12;
  localparam int          PM_WORDS_SMALL = 2048;
  localparam int          PM_WORDS_LARGE = 4096;
  localparam logic [11:0] RESET_VEC      = 12'h000;
  localparam logic [11:0] INT_VEC        = 12'h004;
  localparam logic [1:0]  PHASE_LAST     = 2'h3;
  localparam int          TABLE_CYCLES   = 2;
  localparam logic [7:0]  TBH_USED_MASK  = 8'hFF;
  localparam logic [4:0]  HDR_LAST       = 5'h0E;
  localparam logic [4:0]  DATA_FIRST     = 5'h0F;
  localparam logic [4:0]  FRAME_LAST     = 5'h1E;
  localparam logic [1:0]  TGT_FLASH      = 2'h0;
  localparam logic [1:0]  TGT_EEPROM     = 2'h1;
  localparam logic [1:0]  TGT_DEBUG      = 2'h2;

  typedef enum logic {
    PMT_FETCH,
    PMT_TABLE_SLOT
  } pmt_state_t;

  // Serial frame header, first bit in is the write flag.
  typedef struct packed {
    logic        wr;
    logic [1:0]  tgt;
    logic [11:0] addr;
  } pmt_ser_hdr_t;
endpackage

// >>> hdl/pmt_program_memory.sv
// Program memory with fetch, table read and serial programming access.
`timescale 1ns/10ps
// How it works
// R1 - 16-bit words, 2K or 4K per variant
// R2 - Word 000H reset entry, 004H interrupt entry
// R3 - After reset fetching starts at 000H
// R4 - Table address is high pointer over low
// R5 - Low table byte goes to operand register
// R6 - High table byte overwrites the latch
// R7 - Latch bits without word bits read zero
// R8 - Table instructions take two instruction cycles
// R9 - Software cannot write the high latch
// R10 - Software avoids table reads in interrupts
// R11 - Serial data line plus clock, both directions
// R12 - Only programmer drives programming pins then
// R13 - Debug data bidirectional, clock input only
// R14 - Emulation: shared functions off, programming stays
// R15 - Table read takes second cycle's fetch slot
module pmt_program_memory #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter bit EMULATION     = 1'b0
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        pc_load_in,
  input  wire logic [11:0] pc_load_addr_in,
  input  wire logic        int_ack_in,
  input  wire logic        tbl_req_in,
  input  wire logic [7:0]  tblp_in,
  input  wire logic [7:0]  tbhp_in,
  input  wire logic        prog_mode_in,
  input  wire logic        prog_serial_clock_in,
  input  wire logic        prog_serial_data_in,
  input  wire logic [7:0]  ee_rdata_in,
  output logic             inst_cycle_out,
  output logic [11:0]      fetch_addr_out,
  output logic [15:0]      instr_word_out,
  output logic [7:0]       tbl_low_out,
  output logic             tbl_done_out,
  output logic [7:0]       table_high_byte_latch_out,
  output logic             cpu_hold_out,
  output logic             prog_serial_data_out,
  output logic             prog_serial_data_oe_out,
  output logic             ee_wr_out,
  output logic [11:0]      ee_addr_out,
  output logic [7:0]       ee_wdata_out,
  output logic             shared_func_en_out
);
  localparam int WORDS = LARGE_VARIANT ? pmt_pkg::PM_WORDS_LARGE : pmt_pkg::PM_WORDS_SMALL;

  // The small variant aliases the upper half onto the lower half.
  function automatic logic [11:0] word_index(input logic [11:0] a);
    word_index = a & 12'(WORDS - 1);
  endfunction

  logic [15:0]           mem [WORDS];
  logic [1:0]            phase_reg;
  logic [11:0]           pc_reg;
  pmt_pkg::pmt_state_t   state_reg;
  logic [15:0]           word_reg;
  logic [11:0]           rd_addr;
  logic [2:0]            clk_sync_reg;
  logic [1:0]            dat_sync_reg;
  logic [1:0]            mode_sync_reg;
  logic                  ser_rise;
  logic                  ser_fall;
  logic                  prog_active;
  logic [4:0]            bit_cnt_reg;
  logic [14:0]           hdr_sh_reg;
  logic [15:0]           dat_sh_reg;
  logic [15:0]           out_sh_reg;
  pmt_pkg::pmt_ser_hdr_t hdr;
  logic                  inst_en;
  logic [15:0]           rd_word;

  assign hdr         = hdr_sh_reg;
  assign prog_active = mode_sync_reg[1];
  assign inst_en     = (phase_reg == pmt_pkg::PHASE_LAST) && !prog_active;
  assign ser_rise    = clk_sync_reg[1] && !clk_sync_reg[2];
  assign ser_fall    = !clk_sync_reg[1] && clk_sync_reg[2];

  // One read port serves fetch, the table slot and the serial port.
  always_comb begin
    if (prog_active) begin
      rd_addr = word_index(hdr.addr);
    end else if (state_reg == pmt_pkg::PMT_TABLE_SLOT) begin
      rd_addr = word_index({tbhp_in[3:0], tblp_in}); // R4 R15
    end else begin
      rd_addr = word_index(pc_reg);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    word_reg <= mem[rd_addr]; // R1
  end

  // Instruction cycle of four system clocks, T1 to T4.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      phase_reg      <= 2'h0;
      inst_cycle_out <= 1'b0;
    end else begin
      inst_cycle_out <= inst_en;
      if (!prog_active) begin
        phase_reg <= phase_reg + 2'h1;
      end
    end
  end

  // Program counter, fetch and table sequencing.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pc_reg                    <= pmt_pkg::RESET_VEC; // R3
      fetch_addr_out            <= pmt_pkg::RESET_VEC; // R2
      state_reg                 <= pmt_pkg::PMT_FETCH;
      instr_word_out            <= 16'h0000;
      tbl_low_out               <= 8'h00;
      tbl_done_out              <= 1'b0;
      table_high_byte_latch_out <= 8'h00;
    end else begin
      tbl_done_out <= 1'b0;
      if (inst_en) begin
        case (state_reg)
          pmt_pkg::PMT_FETCH: begin
            instr_word_out <= word_reg;
            fetch_addr_out <= pc_reg;
            if (int_ack_in) begin
              pc_reg <= pmt_pkg::INT_VEC; // R2
            end else if (pc_load_in) begin
              pc_reg <= word_index(pc_load_addr_in);
            end else begin
              pc_reg <= word_index(pc_reg + 12'h001);
            end
            if (tbl_req_in) begin
              state_reg <= pmt_pkg::PMT_TABLE_SLOT; // R8
            end
          end
          pmt_pkg::PMT_TABLE_SLOT: begin
            // No fetch here, so the counter holds for one cycle.
            tbl_low_out               <= word_reg[7:0]; // R5
            table_high_byte_latch_out <= word_reg[15:8] & pmt_pkg::TBH_USED_MASK; // R6 R7 R9
            tbl_done_out              <= 1'b1; // R8
            state_reg                 <= pmt_pkg::PMT_FETCH;
          end
          default: begin
            state_reg <= pmt_pkg::PMT_FETCH;
          end
        endcase
      end
    end
  end

  // Pins from the programmer are asynchronous to the system clock.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      clk_sync_reg  <= 3'h0;
      dat_sync_reg  <= 2'h0;
      mode_sync_reg <= 2'h0;
      cpu_hold_out  <= 1'b0;
    end else begin
      clk_sync_reg  <= {clk_sync_reg[1:0], prog_serial_clock_in};
      dat_sync_reg  <= {dat_sync_reg[0], prog_serial_data_in};
      mode_sync_reg <= {mode_sync_reg[0], prog_mode_in};
      cpu_hold_out  <= mode_sync_reg[1];
    end
  end

  // Serial frame: write flag, target, 12-bit address, then 16 data bits.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !prog_active) begin
      bit_cnt_reg <= 5'h00;
      hdr_sh_reg  <= 15'h0000;
      dat_sh_reg  <= 16'h0000;
    end else if (ser_rise) begin
      bit_cnt_reg <= (bit_cnt_reg == pmt_pkg::FRAME_LAST) ? 5'h00 : bit_cnt_reg + 5'h01; // R11
      if (bit_cnt_reg <= pmt_pkg::HDR_LAST) begin
        hdr_sh_reg <= {hdr_sh_reg[13:0], dat_sync_reg[1]};
      end else begin
        dat_sh_reg <= {dat_sh_reg[14:0], dat_sync_reg[1]};
      end
    end
  end

  // Writes commit on the last data bit of a write frame.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ee_wr_out    <= 1'b0;
      ee_addr_out  <= 12'h000;
      ee_wdata_out <= 8'h00;
    end else begin
      ee_wr_out <= 1'b0;
      if (prog_active && ser_rise && bit_cnt_reg == pmt_pkg::FRAME_LAST && hdr.wr) begin
        if (hdr.tgt == pmt_pkg::TGT_EEPROM) begin
          ee_wr_out    <= 1'b1; // R11
          ee_addr_out  <= hdr.addr;
          ee_wdata_out <= {dat_sh_reg[6:0], dat_sync_reg[1]};
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (prog_active && ser_rise && bit_cnt_reg == pmt_pkg::FRAME_LAST && hdr.wr
        && hdr.tgt == pmt_pkg::TGT_FLASH) begin
      mem[word_index(hdr.addr)] <= {dat_sh_reg[14:0], dat_sync_reg[1]}; // R1 R11
    end
  end

  // Word offered on a read frame; its top bit must leave first whatever the target.
  always_comb begin
    case (hdr.tgt)
      pmt_pkg::TGT_FLASH:  rd_word = word_reg;
      pmt_pkg::TGT_EEPROM: rd_word = {8'h00, ee_rdata_in};
      // Debug reads exist only on the emulation variant.
      pmt_pkg::TGT_DEBUG:  rd_word = EMULATION ? {table_high_byte_latch_out, pc_reg[7:0]} : 16'h0000; // R13
      default:             rd_word = 16'h0000;
    endcase
  end

  // Read frames: the device drives only during the data bits, on falling edges.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !prog_active) begin
      out_sh_reg              <= 16'h0000;
      prog_serial_data_out    <= 1'b0;
      prog_serial_data_oe_out <= 1'b0; // R12
    end else if (ser_fall && !hdr.wr) begin
      if (bit_cnt_reg == pmt_pkg::DATA_FIRST) begin
        out_sh_reg              <= rd_word;
        prog_serial_data_out    <= rd_word[15];
        prog_serial_data_oe_out <= 1'b1; // R11 R13
      end else if (bit_cnt_reg > pmt_pkg::DATA_FIRST) begin
        out_sh_reg              <= {out_sh_reg[14:0], 1'b0};
        prog_serial_data_out    <= out_sh_reg[14];
        prog_serial_data_oe_out <= 1'b1;
      end else begin
        prog_serial_data_oe_out <= 1'b0;
      end
    end
  end

  // Pin functions shared with the debug pins are disabled on emulation parts.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      shared_func_en_out <= 1'b0;
    end else begin
      shared_func_en_out <= !EMULATION && !prog_active; // R14
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_reset_fetch_start: assert property ($rose(rst_n_in) |-> pc_reg == pmt_pkg::RESET_VEC) // R3
    else $error("Program counter not at reset entry after reset.");
  chk_int_entry_word: assert property (inst_en && state_reg == pmt_pkg::PMT_FETCH && int_ack_in
                                       |=> pc_reg == pmt_pkg::INT_VEC) // R2
    else $error("Interrupt acknowledge did not load entry word.");
  chk_table_two_cycles: assert property (inst_en && state_reg == pmt_pkg::PMT_FETCH && tbl_req_in
                                         |-> ##5 tbl_done_out) // R8
    else $error("Table read did not finish in two instruction cycles.");
  chk_table_slot_pc: assert property (inst_en && state_reg == pmt_pkg::PMT_TABLE_SLOT
                                      |=> $stable(pc_reg)) // R15
    else $error("Program counter moved during table slot.");
  chk_table_addr_form: assert property (state_reg == pmt_pkg::PMT_TABLE_SLOT && !prog_active
                                        |-> rd_addr == word_index({tbhp_in[3:0], tblp_in})) // R4
    else $error("Table address not formed from pointer pair.");
  chk_high_latch_load: assert property (inst_en && state_reg == pmt_pkg::PMT_TABLE_SLOT
                                        |=> table_high_byte_latch_out == ($past(word_reg[15:8]) & pmt_pkg::TBH_USED_MASK)) // R6
    else $error("High latch not loaded from upper byte.");
  chk_low_byte_out: assert property (tbl_done_out |-> tbl_low_out == $past(word_reg[7:0])) // R5
    else $error("Low table byte wrong.");
  chk_high_latch_hold: assert property (!(inst_en && state_reg == pmt_pkg::PMT_TABLE_SLOT)
                                        |=> $stable(table_high_byte_latch_out)) // R9
    else $error("High latch changed outside a table read.");
  chk_unused_bits_zero: assert property ((table_high_byte_latch_out & ~pmt_pkg::TBH_USED_MASK) == 8'h00) // R7
    else $error("Unused latch bits not zero.");
  chk_drive_data_only: assert property (prog_serial_data_oe_out |-> prog_active && !hdr.wr) // R11
    else $error("Data pin driven outside a read frame.");
  chk_shared_off_emul: assert property (EMULATION |-> !shared_func_en_out) // R14
    else $error("Shared pin functions active on emulation part.");
  chk_addr_in_range: assert property (int'(pc_reg) < WORDS) // R1
    else $error("Program counter beyond memory size.");

  cov_table_read:   cover property (tbl_done_out);
  cov_int_entry:    cover property (inst_en && int_ack_in);
  cov_serial_read:  cover property ($rose(prog_serial_data_oe_out));
  cov_serial_write: cover property (prog_active && ser_rise && bit_cnt_reg == pmt_pkg::FRAME_LAST && hdr.wr);
endmodule

// >>> tb/pmt_prog_model.sv
// Serial programmer model for the programming clock and data lines.
`timescale 1ns/10ps
module pmt_prog_model (
  output logic     prog_serial_clock_out,
  output logic     prog_data_drive_out,
  output logic     prog_data_oe_out,
  input  wire logic prog_data_wire_in
);
  localparam time HALF_SCK = 400;
  initial begin
    prog_serial_clock_out = 1'b0;
    prog_data_drive_out   = 1'b0;
    prog_data_oe_out      = 1'b0;
  end
  // The clock rests low between frames; on a read the line is freed after the header.
  task automatic frame(input logic wr, input logic [1:0] tgt, input logic [11:0] addr,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [30:0] bits;
    bits  = {wr, tgt, addr, wdata};
    rdata = 16'h0000;
    for (int i = 30; i >= 0; i--) begin
      prog_data_oe_out    = wr || (i > 15);
      prog_data_drive_out = bits[i];
      #HALF_SCK prog_serial_clock_out = 1'b1;
      if (i < 16) rdata = {rdata[14:0], prog_data_wire_in};
      #HALF_SCK prog_serial_clock_out = 1'b0;
    end
    prog_data_oe_out = 1'b0;
    #(10 * HALF_SCK);
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the program memory and table read block.
`timescale 1ns/10ps
module tb;
  logic        sys_clk_in, rst_n_in, pc_load_in, int_ack_in, tbl_req_in, prog_mode_in;
  logic [11:0] pc_load_addr_in, fa_out, ee_a_out, ee_a_log;
  logic [7:0]  tblp_in, tbhp_in, ee_rdata_in, low_out, latch_out, ee_d_out, ee_d_log;
  logic        ic_out, done_out, hold_out, sda_out, sda_oe, ee_wr_out, shared_out;
  logic        sck, host_d, host_oe, sda_wire;
  logic        idle_tog = 1'b0;
  logic [15:0] instr_out, rd;
  int          mismatches, check_count;
  pmt_program_memory #(.LARGE_VARIANT(1'b1), .EMULATION(1'b0)) dut_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .pc_load_in(pc_load_in),
    .pc_load_addr_in(pc_load_addr_in), .int_ack_in(int_ack_in), .tbl_req_in(tbl_req_in),
    .tblp_in(tblp_in), .tbhp_in(tbhp_in), .prog_mode_in(prog_mode_in), .prog_serial_clock_in(sck),
    .prog_serial_data_in(sda_wire), .ee_rdata_in(ee_rdata_in), .inst_cycle_out(ic_out),
    .fetch_addr_out(fa_out), .instr_word_out(instr_out), .tbl_low_out(low_out), .tbl_done_out(done_out),
    .table_high_byte_latch_out(latch_out), .cpu_hold_out(hold_out), .prog_serial_data_out(sda_out),
    .prog_serial_data_oe_out(sda_oe), .ee_wr_out(ee_wr_out), .ee_addr_out(ee_a_out),
    .ee_wdata_out(ee_d_out), .shared_func_en_out(shared_out));
  pmt_prog_model prog_u (.prog_serial_clock_out(sck), .prog_data_drive_out(host_d),
    .prog_data_oe_out(host_oe), .prog_data_wire_in(sda_wire));
  // A freed line toggles every clock, so a stale bit never passes for data.
  assign sda_wire = sda_oe ? sda_out : (host_oe ? host_d : idle_tog);
  always @(posedge sys_clk_in) begin
    idle_tog <= ~idle_tog;
    if (ee_wr_out === 1'b1) begin
      ee_a_log <= ee_a_out;
      ee_d_log <= ee_d_out;
    end
  end
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_ic();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (ic_out !== 1'b1 && n < 40);
    if (ic_out !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  // Requests are held across the next instruction-cycle end and dropped on it.
  task automatic core_req(input logic ia, input logic pl, input logic tr, input logic [11:0] tgt);
    wait_ic();
    @(posedge sys_clk_in);
    int_ack_in      <= ia;
    pc_load_in      <= pl;
    tbl_req_in      <= tr;
    pc_load_addr_in <= tgt;
    repeat (3) @(posedge sys_clk_in);
    int_ack_in <= 1'b0;
    pc_load_in <= 1'b0;
    tbl_req_in <= 1'b0;
    @(negedge sys_clk_in);
  endtask
  task automatic t_vectors();
    // A new counter value shows as a fetch address one instruction cycle later.
    core_req(1'b0, 1'b1, 1'b0, 12'h123);
    wait_ic();
    cmp(16'(fa_out), 16'h0123, "jump");
    core_req(1'b1, 1'b1, 1'b0, 12'h456);
    wait_ic();
    cmp(16'(fa_out), 16'(pmt_pkg::INT_VEC), "int entry");
  endtask
  task automatic t_table(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] w);
    int          n;
    logic [11:0] fa;
    @(posedge sys_clk_in);
    tbhp_in <= hi;
    tblp_in <= lo;
    core_req(1'b0, 1'b0, 1'b1, 12'h000);
    fa = fa_out;
    n  = 0;
    while (done_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (done_out !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    cmp(16'(n), 16'h0004, "table latency");
    cmp(16'(fa_out), 16'(fa), "fetch in slot");
    cmp(16'(low_out), 16'(w[7:0]), "low byte");
    cmp(16'(latch_out), 16'(w[15:8] & pmt_pkg::TBH_USED_MASK), "latch");
  endtask
  task automatic t_program();
    @(posedge sys_clk_in);
    prog_mode_in <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    cmp(16'({hold_out, shared_out}), 16'h0002, "hold in prog");
    prog_u.frame(1'b1, pmt_pkg::TGT_FLASH, 12'h706, 16'h1A5B, rd);
    prog_u.frame(1'b1, pmt_pkg::TGT_FLASH, 12'h705, 16'h3C0F, rd);
    prog_u.frame(1'b1, pmt_pkg::TGT_FLASH, 12'hFFF, 16'hA5C3, rd);
    prog_u.frame(1'b0, pmt_pkg::TGT_FLASH, 12'h706, 16'h0000, rd);
    cmp(rd, 16'h1A5B, "flash readback");
    prog_u.frame(1'b1, pmt_pkg::TGT_EEPROM, 12'h02A, 16'h00C3, rd);
    cmp(16'(ee_a_log), 16'h002A, "ee addr");
    cmp(16'(ee_d_log), 16'h00C3, "ee data");
    prog_u.frame(1'b0, pmt_pkg::TGT_EEPROM, 12'h02A, 16'h0000, rd);
    cmp(rd, 16'h005A, "ee readback");
    prog_u.frame(1'b0, pmt_pkg::TGT_DEBUG, 12'h000, 16'h0000, rd);
    cmp(rd, 16'h0000, "debug read off");
    @(posedge sys_clk_in);
    prog_mode_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    cmp(16'({hold_out, shared_out}), 16'h0001, "run mode");
  endtask
  initial begin
    {rst_n_in, pc_load_in, int_ack_in, tbl_req_in, prog_mode_in, idle_tog} = 6'h00;
    {pc_load_addr_in, tblp_in, tbhp_in} = 28'h0000000;
    ee_rdata_in = 8'h5A;
    mismatches  = 0;
    check_count = 0;
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    wait_ic();
    cmp(16'(fa_out), 16'(pmt_pkg::RESET_VEC), "reset fetch");
    t_vectors();
    t_program();
    t_table(8'h07, 8'h06, 16'h1A5B);
    t_table(8'h07, 8'h05, 16'h3C0F);
    t_table(8'h0F, 8'hFF, 16'hA5C3);
    report_and_stop();
  end
endmodule
